/* pkg/meter_dsp_pkg.sv */
/*
  Constants, register map and carrier types for the three-phase
  voltage rms and active power datapath.
  Assumes a 25 MHz system clock and 16-bit ADC samples on that clock.
*/
`default_nettype none
package meter_dsp_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int SAMPLE_W        = 16;
  localparam int CUR_W           = 17;
  localparam int CAL_W           = 12;
  localparam int RMS_W           = 24;
  localparam int ACC_W           = 41;
  localparam int ENERGY_W        = 16;
  localparam int ADDR_W          = 8;
  localparam int GAIN_SHIFT      = 12;
  localparam int VOLTAGE_RMS_RESULT_OS_SHIFT   = 6;
  localparam int WATT_OS_FRAC    = 4;
  localparam int RMS_SCALE       = 284;
  localparam int VLPF1_SHIFT     = 3;
  localparam int CLOCK_HZ        = 25_000_000;
  localparam int RMS_DIV         = 12;
  localparam int ACC_DIV         = 4;
  localparam int VOLTAGE_RMS_RESULT_TAU_MS     = 100;
  localparam int POWER_TAU_MS    = 160;
  localparam int VOLTAGE_RMS_RESULT_TAU_CYC    = CLOCK_HZ / RMS_DIV / 1000 * VOLTAGE_RMS_RESULT_TAU_MS;
  localparam int POWER_TAU_CYC   = CLOCK_HZ / ACC_DIV / 1000 * POWER_TAU_MS;
  localparam int VOLTAGE_RMS_RESULT_LPF_SHIFT  = $clog2(VOLTAGE_RMS_RESULT_TAU_CYC);
  localparam int POWER_LPF_SHIFT = $clog2(POWER_TAU_CYC);

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_COMP_MODE  = 8'h00;
  localparam logic [7:0] ADDR_PULSE_NUM  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
  localparam logic [2:0] PH_VOLTAGE_RMS_RESULT         = 3'h0;
  localparam logic [2:0] PH_VOLTAGE_RMS_RESULT_OFFSET  = 3'h1;
  localparam logic [2:0] PH_VOLTAGE_RMS_RESULT_GAIN    = 3'h2;
  localparam logic [2:0] PH_ENERGY       = 3'h3;
  localparam logic [2:0] PH_POWER_GAIN   = 3'h4;
  localparam logic [2:0] PH_POWER_OFFSET = 3'h5;
  localparam int REVERSE_BIT     = 17;
  localparam int CONSEL_LSB      = 0;
  localparam int PHSEL_LSB       = 2;
  localparam int NEG_A_BIT       = 15;
  localparam int NUM_W           = 13;
  localparam logic [1:0] CONSEL_SPLIT_AC = 2'h1;
  localparam logic [1:0] CONSEL_SPLIT_A  = 2'h2;
  localparam logic [4:0] COMP_MODE_RESET = 5'h1C;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [CAL_W-1:0] voltage_rms_result_gain;
    logic [CAL_W-1:0] voltage_rms_result_offset;
    logic [CAL_W-1:0] power_gain;
    logic [CAL_W-1:0] power_offset;
  } phase_cal_type;

  typedef struct packed {
    logic [RMS_W-1:0]    voltage_rms_result;
    logic [ENERGY_W-1:0] energy;
    logic                negative;
    logic                sign_flip;
  } phase_result_type;

endpackage
`default_nettype wire

/* hw/phase_dsp.sv */
/*
  One phase: voltage gain, first low-pass, mean-absolute rms with
  offset, power product, power low-pass with offset and gain, energy.
  Assumes tick_rms and tick_acc are one-cycle strobes from the top.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_dsp (
  input  wire logic                                        clock,
  input  wire logic                                        nrst,
  input  wire logic                                        tick_rms,
  input  wire logic                                        tick_acc,
  input  wire logic signed [meter_dsp_pkg::SAMPLE_W-1:0]   v_sample,
  input  wire logic signed [meter_dsp_pkg::CUR_W-1:0]      i_sample,
  input  wire meter_dsp_pkg::phase_cal_type                cal,
  output var  meter_dsp_pkg::phase_result_type             res
);

  // ****************************************************************
  // Voltage path
  // ****************************************************************
  logic signed [27:0] v_gprod;
  logic signed [16:0] v_scaled;
  logic signed [19:0] voltage_lowpass_stage_ff;
  logic signed [16:0] voltage_lowpass_stage_out;
  logic        [16:0] v_abs;
  logic        [34:0] mav_ff;
  logic        [16:0] mav;
  logic        [25:0] rms_raw;
  logic signed [27:0] rms_cor;
  logic        [23:0] nxt_voltage_rms_result;
  logic        [23:0] voltage_rms_result_ff;

  assign v_gprod  = v_sample * $signed(cal.voltage_rms_result_gain);
  assign v_scaled = 17'(v_sample) + 17'(v_gprod >>> meter_dsp_pkg::GAIN_SHIFT);
  assign voltage_lowpass_stage_out = 17'(voltage_lowpass_stage_ff >>> meter_dsp_pkg::VLPF1_SHIFT);
  assign v_abs    = voltage_lowpass_stage_out[16] ? 17'(-voltage_lowpass_stage_out) : 17'(voltage_lowpass_stage_out);
  assign mav      = 17'(mav_ff >> meter_dsp_pkg::VOLTAGE_RMS_RESULT_LPF_SHIFT);
  assign rms_raw  = mav * 9'(meter_dsp_pkg::RMS_SCALE);
  assign rms_cor  = $signed({2'h0, rms_raw})
                  + (28'($signed(cal.voltage_rms_result_offset)) <<< meter_dsp_pkg::VOLTAGE_RMS_RESULT_OS_SHIFT);
  assign nxt_voltage_rms_result = rms_cor[27] ? 24'h000000 :
                    (|rms_cor[26:24]) ? 24'hFFFFFF : rms_cor[23:0];

  always_ff @(posedge clock) begin
    if (!nrst) begin
      voltage_lowpass_stage_ff <= '0;
      mav_ff  <= '0;
      voltage_rms_result_ff <= '0;
    end else if (tick_rms) begin
      voltage_lowpass_stage_ff <= voltage_lowpass_stage_ff + 20'(v_scaled) - 20'(voltage_lowpass_stage_out);
      mav_ff  <= mav_ff + 35'(v_abs) - 35'(mav);
      voltage_rms_result_ff <= nxt_voltage_rms_result;
    end
  end

  // ****************************************************************
  // Power path
  // ****************************************************************
  logic signed [33:0] p_inst;
  logic signed [37:0] p_fx;
  logic signed [57:0] power_lowpass_stage_ff;
  logic signed [37:0] p_avg;
  logic signed [49:0] p_gprod;
  logic signed [37:0] p_gain;
  logic signed [33:0] p_out;
  logic        [40:0] acc_ff;
  logic               sign_ff;

  assign p_inst  = v_scaled * i_sample;
  assign p_fx    = (38'(p_inst) <<< meter_dsp_pkg::WATT_OS_FRAC)
                 + 38'($signed(cal.power_offset));
  assign p_avg   = 38'(power_lowpass_stage_ff >>> meter_dsp_pkg::POWER_LPF_SHIFT);
  assign p_gprod = p_avg * $signed(cal.power_gain);
  assign p_gain  = p_avg + 38'(p_gprod >>> meter_dsp_pkg::GAIN_SHIFT);
  assign p_out   = 34'(p_gain >>> meter_dsp_pkg::WATT_OS_FRAC);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      power_lowpass_stage_ff <= '0;
      acc_ff  <= '0;
      sign_ff <= 1'b0;
    end else if (tick_acc) begin
      power_lowpass_stage_ff <= power_lowpass_stage_ff + 58'(p_fx) - 58'(p_avg);
      acc_ff  <= acc_ff + 41'(p_out);
      sign_ff <= p_out[33];
    end
  end

  assign res.voltage_rms_result      = voltage_rms_result_ff;
  assign res.energy    = acc_ff[40:25];
  assign res.negative  = sign_ff;
  assign res.sign_flip = tick_acc & (p_out[33] ^ sign_ff);

endmodule
`default_nettype wire

/* hw/meter_dsp_top.sv */
/*
  Three-phase voltage rms and active power block with an AXI4-Lite
  register slave and an active-low interrupt output.
  Assumes the sample inputs are produced on CLOCK and stay stable
  between updates; one outstanding read and write per the bus.
*/
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module meter_dsp_top (
  input  wire logic                                      CLOCK,
  input  wire logic                                      NRST,
  input  wire logic [2:0][meter_dsp_pkg::SAMPLE_W-1:0]   VOLTAGE_SAMPLE,
  input  wire logic [2:0][meter_dsp_pkg::SAMPLE_W-1:0]   CURRENT_SAMPLE,
  input  wire logic [meter_dsp_pkg::ADDR_W-1:0]          AWADDR,
  input  wire logic                                      AWVALID,
  output logic                                           AWREADY,
  input  wire logic [31:0]                               WDATA,
  input  wire logic [3:0]                                WSTRB,
  input  wire logic                                      WVALID,
  output logic                                           WREADY,
  output logic [1:0]                                     BRESP,
  output logic                                           BVALID,
  input  wire logic                                      BREADY,
  input  wire logic [meter_dsp_pkg::ADDR_W-1:0]          ARADDR,
  input  wire logic                                      ARVALID,
  output logic                                           ARREADY,
  output logic [31:0]                                    RDATA,
  output logic [1:0]                                     RRESP,
  output logic                                           RVALID,
  input  wire logic                                      RREADY,
  output logic                                           IRQ_N
);

  // ****************************************************************
  // Update strobes
  // ****************************************************************
  logic [3:0] rms_cnt_ff;
  logic [1:0] acc_cnt_ff;
  logic       tick_rms;
  logic       tick_acc;

  assign tick_rms = (rms_cnt_ff == 4'(meter_dsp_pkg::RMS_DIV - 1));
  assign tick_acc = (acc_cnt_ff == 2'(meter_dsp_pkg::ACC_DIV - 1));

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rms_cnt_ff <= '0;
      acc_cnt_ff <= '0;
    end else begin
      rms_cnt_ff <= tick_rms ? 4'h0 : rms_cnt_ff + 4'h1;
      acc_cnt_ff <= acc_cnt_ff + 2'h1;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [4:0]                        comp_mode_ff;
  logic [meter_dsp_pkg::NUM_W-1:0]   pulse_num_ff;
  logic                              rev_flag_ff;
  logic                              rev_en_ff;
  meter_dsp_pkg::phase_cal_type      cal_ff [3];
  meter_dsp_pkg::phase_result_type   res [3];
  logic [1:0]                        consel;
  logic [2:0]                        phase_sel;

  assign consel    = comp_mode_ff[meter_dsp_pkg::CONSEL_LSB +: 2];
  assign phase_sel = comp_mode_ff[meter_dsp_pkg::PHSEL_LSB +: 3];

  // ****************************************************************
  // Current selection per accumulation mode
  // ****************************************************************
  logic signed [meter_dsp_pkg::CUR_W-1:0] cur_ext [3];
  logic signed [meter_dsp_pkg::CUR_W-1:0] cur_sel [3];
  logic                                   split;

  assign split = (consel == meter_dsp_pkg::CONSEL_SPLIT_AC)
               | (consel == meter_dsp_pkg::CONSEL_SPLIT_A);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ext
      assign cur_ext[g] = 17'($signed(CURRENT_SAMPLE[g]));
    end
  endgenerate

  assign cur_sel[0] = split ? cur_ext[0] - cur_ext[1] : cur_ext[0];
  assign cur_sel[1] = split ? 17'h00000 : cur_ext[1];
  assign cur_sel[2] = (consel == meter_dsp_pkg::CONSEL_SPLIT_AC) ?
                      cur_ext[2] - cur_ext[1] : cur_ext[2];

  // ****************************************************************
  // Phase datapaths
  // ****************************************************************
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      phase_dsp u_phase (
        .clock    (CLOCK),
        .nrst     (NRST),
        .tick_rms (tick_rms),
        .tick_acc (tick_acc),
        .v_sample ($signed(VOLTAGE_SAMPLE[g])),
        .i_sample (cur_sel[g]),
        .cal      (cal_ff[g]),
        .res      (res[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Reverse power detection
  // ****************************************************************
  logic [2:0] flip_vec;
  logic [2:0] neg_vec;
  logic       rev_event;

  generate
    for (g = 0; g < 3; g++) begin : g_flags
      assign flip_vec[g] = res[g].sign_flip;
      assign neg_vec[2-g] = res[g].negative;
    end
  endgenerate

  assign rev_event = |(flip_vec & phase_sel);
  assign IRQ_N     = ~(rev_flag_ff & rev_en_ff);

  // ****************************************************************
  // Write channel
  // ****************************************************************
  logic        aw_ff;
  logic [7:0]  awaddr_ff;
  logic        w_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        do_write;
  logic [31:0] wmask;
  logic [2:0]  wr_idx;
  logic [2:0]  wr_grp;
  logic        wr_ph_ok;
  logic        wr_hit;
  logic        wr_comp;
  logic        wr_num;
  logic        wr_clear;
  logic        wr_enable;
  logic [31:0] wr_word;

  assign AWREADY   = ~aw_ff & ~bvalid_ff;
  assign WREADY    = ~w_ff & ~bvalid_ff;
  assign BVALID    = bvalid_ff;
  assign BRESP     = bresp_ff;
  assign do_write  = aw_ff & w_ff & ~bvalid_ff;
  assign wmask     = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                      {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wr_word   = wdata_ff & wmask;
  assign wr_idx    = awaddr_ff[4:2];
  assign wr_grp    = awaddr_ff[7:5];
  assign wr_ph_ok  = (wr_grp != 3'h0) & (wr_grp <= 3'h3)
                   & (wr_idx <= meter_dsp_pkg::PH_POWER_OFFSET) & (awaddr_ff[1:0] == 2'h0);
  assign wr_comp   = (awaddr_ff == meter_dsp_pkg::ADDR_COMP_MODE);
  assign wr_num    = (awaddr_ff == meter_dsp_pkg::ADDR_PULSE_NUM);
  assign wr_clear  = (awaddr_ff == meter_dsp_pkg::ADDR_IRQ_CLEAR);
  assign wr_enable = (awaddr_ff == meter_dsp_pkg::ADDR_IRQ_ENABLE);
  assign wr_hit    = wr_comp | wr_num | wr_clear | wr_enable
                   | (awaddr_ff == meter_dsp_pkg::ADDR_IRQ_STATUS) | wr_ph_ok;

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      aw_ff     <= 1'b0;
      awaddr_ff <= '0;
      w_ff      <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= meter_dsp_pkg::RESP_OKAY;
    end else begin
      if (AWVALID & AWREADY) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= AWADDR;
      end else if (do_write) begin
        aw_ff <= 1'b0;
      end
      if (WVALID & WREADY) begin
        w_ff     <= 1'b1;
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end else if (do_write) begin
        w_ff <= 1'b0;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? meter_dsp_pkg::RESP_OKAY : meter_dsp_pkg::RESP_SLVERR;
      end else if (BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register updates
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      comp_mode_ff <= meter_dsp_pkg::COMP_MODE_RESET;
      pulse_num_ff <= '0;
      rev_en_ff    <= 1'b0;
    end else if (do_write) begin
      if (wr_comp & wstrb_ff[0]) begin
        comp_mode_ff <= wdata_ff[4:0];
      end
      if (wr_num) begin
        pulse_num_ff <= (pulse_num_ff & ~wmask[12:0]) | wr_word[12:0];
      end
      if (wr_enable & wstrb_ff[2]) begin
        rev_en_ff <= wdata_ff[meter_dsp_pkg::REVERSE_BIT];
      end
    end
  end

  // Set beats a simultaneous clear
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rev_flag_ff <= 1'b0;
    end else if (rev_event) begin
      rev_flag_ff <= 1'b1;
    end else if (do_write & wr_clear & wr_word[meter_dsp_pkg::REVERSE_BIT]) begin
      rev_flag_ff <= 1'b0;
    end
  end

  generate
    for (g = 0; g < 3; g++) begin : g_cal
      logic       sel;
      logic [11:0] nxt_val [4];
      assign sel = do_write & wr_ph_ok & (wr_grp == 3'(g + 1));
      assign nxt_val[0] = (cal_ff[g].voltage_rms_result_gain & ~wmask[11:0]) | wr_word[11:0];
      assign nxt_val[1] = (cal_ff[g].voltage_rms_result_offset & ~wmask[11:0]) | wr_word[11:0];
      assign nxt_val[2] = (cal_ff[g].power_gain & ~wmask[11:0]) | wr_word[11:0];
      assign nxt_val[3] = (cal_ff[g].power_offset & ~wmask[11:0]) | wr_word[11:0];
      always_ff @(posedge CLOCK) begin
        if (!NRST) begin
          cal_ff[g] <= '0;
        end else if (sel) begin
          if (wr_idx == meter_dsp_pkg::PH_VOLTAGE_RMS_RESULT_GAIN)    cal_ff[g].voltage_rms_result_gain    <= nxt_val[0];
          if (wr_idx == meter_dsp_pkg::PH_VOLTAGE_RMS_RESULT_OFFSET)  cal_ff[g].voltage_rms_result_offset  <= nxt_val[1];
          if (wr_idx == meter_dsp_pkg::PH_POWER_GAIN)   cal_ff[g].power_gain   <= nxt_val[2];
          if (wr_idx == meter_dsp_pkg::PH_POWER_OFFSET) cal_ff[g].power_offset <= nxt_val[3];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [2:0]  rd_idx;
  logic [2:0]  rd_grp;
  logic [1:0]  rd_ph;
  logic        rd_ph_ok;
  logic        rd_hit;
  logic [31:0] rd_phase_word;
  logic [31:0] rd_word;
  meter_dsp_pkg::phase_cal_type    rd_cal;
  meter_dsp_pkg::phase_result_type rd_res;

  assign ARREADY  = ~rvalid_ff;
  assign RVALID   = rvalid_ff;
  assign RDATA    = rdata_ff;
  assign RRESP    = rresp_ff;
  assign rd_idx   = ARADDR[4:2];
  assign rd_grp   = ARADDR[7:5];
  assign rd_ph    = 2'(rd_grp - 3'h1);
  assign rd_ph_ok = (rd_grp != 3'h0) & (rd_grp <= 3'h3)
                  & (rd_idx <= meter_dsp_pkg::PH_POWER_OFFSET) & (ARADDR[1:0] == 2'h0);
  assign rd_cal   = cal_ff[rd_ph];
  assign rd_res   = res[rd_ph];

  assign rd_phase_word =
      (rd_idx == meter_dsp_pkg::PH_VOLTAGE_RMS_RESULT)         ? {8'h00, rd_res.voltage_rms_result} :
      (rd_idx == meter_dsp_pkg::PH_VOLTAGE_RMS_RESULT_OFFSET)  ? {20'h00000, rd_cal.voltage_rms_result_offset} :
      (rd_idx == meter_dsp_pkg::PH_VOLTAGE_RMS_RESULT_GAIN)    ? {20'h00000, rd_cal.voltage_rms_result_gain} :
      (rd_idx == meter_dsp_pkg::PH_ENERGY)       ? {16'h0000, rd_res.energy} :
      (rd_idx == meter_dsp_pkg::PH_POWER_GAIN)   ? {20'h00000, rd_cal.power_gain} :
                                                   {20'h00000, rd_cal.power_offset};

  assign rd_word =
      rd_ph_ok ? rd_phase_word :
      (ARADDR == meter_dsp_pkg::ADDR_COMP_MODE)  ? {27'h0000000, comp_mode_ff} :
      (ARADDR == meter_dsp_pkg::ADDR_PULSE_NUM)  ? {16'h0000, neg_vec, pulse_num_ff} :
      (ARADDR == meter_dsp_pkg::ADDR_IRQ_STATUS) ? 32'(rev_flag_ff) << meter_dsp_pkg::REVERSE_BIT :
      (ARADDR == meter_dsp_pkg::ADDR_IRQ_ENABLE) ? 32'(rev_en_ff) << meter_dsp_pkg::REVERSE_BIT :
                                                   32'h00000000;

  assign rd_hit = rd_ph_ok
                | (ARADDR == meter_dsp_pkg::ADDR_COMP_MODE)
                | (ARADDR == meter_dsp_pkg::ADDR_PULSE_NUM)
                | (ARADDR == meter_dsp_pkg::ADDR_IRQ_STATUS)
                | (ARADDR == meter_dsp_pkg::ADDR_IRQ_CLEAR)
                | (ARADDR == meter_dsp_pkg::ADDR_IRQ_ENABLE);

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= meter_dsp_pkg::RESP_OKAY;
    end else if (ARVALID & ARREADY) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_hit ? meter_dsp_pkg::RESP_OKAY : meter_dsp_pkg::RESP_SLVERR;
    end else if (RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* tb/meter_dsp_props.sv */
/* Bus and interrupt checker for meter_dsp_top.
   Assumes binding to that module's ports only. */
`timescale 1ns/1ps
`default_nettype none
module meter_dsp_props (
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic [7:0]  AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0]  WSTRB,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [7:0]  ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic        IRQ_N
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  wire logic bad = ARADDR > 8'h7C || ARADDR[1:0] != 2'h0
    || ARADDR[4:0] > (ARADDR[7:5] == 3'h0 ? 5'h10 : 5'h14);
  sequence s_ar; ARVALID && ARREADY; endsequence
  sequence s_wr; AWVALID && AWREADY && WVALID && WREADY; endsequence
  property p_rd_ans; s_ar |=> RVALID; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_rd_block; RVALID |-> !ARREADY; endproperty
  a_rd_block: assert property (p_rd_block) else $error("read taken while busy");
  property p_rd_bad;
    ARVALID && ARREADY && bad |=> RRESP == meter_dsp_pkg::RESP_SLVERR && RDATA == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read accepted");
  property p_wr_ans; s_wr |=> !BVALID ##1 BVALID; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_wr_hold; BVALID && !BREADY |=> BVALID; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  property p_wr_block; BVALID |-> !AWREADY && !WREADY; endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken while busy");
  property p_irq_off;
    s_wr ##0 (AWADDR == meter_dsp_pkg::ADDR_IRQ_ENABLE && WSTRB[2] && !WDATA[17]) |-> ##2 IRQ_N;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt active");
endmodule
bind meter_dsp_top meter_dsp_props u_props (.CLOCK(CLOCK), .NRST(NRST),
  .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
  .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
  .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .IRQ_N(IRQ_N));
`default_nettype wire

/* tb/sample_source.sv */
/* Steady per-phase voltage and current sample source.
   Assumes the bench sets the levels just after an edge. */
`timescale 1ns/1ps
`default_nettype none
module sample_source (
  input  wire logic             clock,
  input  wire logic [2:0][15:0] v_level,
  input  wire logic [2:0][15:0] i_level,
  output var  logic [2:0][15:0] v_ff,
  output var  logic [2:0][15:0] i_ff
);
  initial begin
    v_ff = '0;
    i_ff = '0;
  end
  // Levels held steady so rms reads settle
  always @(posedge clock) begin
    v_ff <= v_level;
    i_ff <= i_level;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/* Bench for meter_dsp_top: register table, then sign detection.
   Assumes the bound checker and the sample source model. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } row_type;
  logic             clock = 1'b0;
  logic             nrst = 1'b0;
  logic [7:0]       awaddr = 8'h0, araddr = 8'h0;
  logic [31:0]      wdata = 32'h0, rdata, data, vrms0;
  logic [3:0]       wstrb = 4'hF;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic             rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq_n;
  logic [1:0]       bresp, rresp, resp;
  logic [2:0][15:0] v_lvl = '0, i_lvl = '0, v_smp, i_smp;
  int               miscompares = 0, n_tests = 0, k;
  row_type rows [10] = '{
    '{1'b1, 8'h20, 32'hFFFFFF, 32'h0, 2'h0},
    '{1'b1, 8'h2C, 32'hFFFF, 32'h0, 2'h0},
    '{1'b0, 8'h00, 32'h0, 32'h1C, 2'h0},
    '{1'b1, 8'h24, 32'hFFFFFFFF, 32'hFFF, 2'h0},
    '{1'b1, 8'h48, 32'h800, 32'h800, 2'h0},
    '{1'b1, 8'h70, 32'h12345ABC, 32'hABC, 2'h0},
    '{1'b1, 8'h34, 32'h7FF, 32'h7FF, 2'h0},
    '{1'b1, 8'h38, 32'h1, 32'h0, 2'h2},
    '{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0, 2'h0},
    '{1'b1, 8'h10, 32'h20000, 32'h20000, 2'h0}};
  sample_source u_sample_source (.clock(clock), .v_level(v_lvl), .i_level(i_lvl),
    .v_ff(v_smp), .i_ff(i_smp));
  meter_dsp_top u_meter_dsp_top (.CLOCK(clock), .NRST(nrst), .VOLTAGE_SAMPLE(v_smp),
    .CURRENT_SAMPLE(i_smp), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .IRQ_N(irq_n));
  always #20 clock = ~clock;
  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task give_verdict;
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_t, w_t, b_t;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    bready <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clock);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      r = bresp;
      @(posedge clock);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      bready <= !b_t;
      n++;
    end while (!b_t && n < 50);
    if (!b_t) miscompares++;
    if (!b_t) give_verdict;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic a_t, t;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clock);
      a_t = arvalid && arready;
      t = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (a_t) arvalid <= 1'b0;
      rready <= !t;
      n++;
    end while (!t && n < 50);
    if (!t) miscompares++;
    if (!t) give_verdict;
  endtask
  task wait_num(input logic b);
    int n;
    n = 0;
    do begin
      rd(8'h04, data, resp);
      n++;
    end while (data[15] !== b && n < 300);
    if (data[15] !== b) miscompares++;
    if (data[15] !== b) give_verdict;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    chk(32'(irq_n), 32'h1);
    foreach (rows[j]) begin
      if (rows[j].wr) begin
        wr(rows[j].a, rows[j].d, resp);
        chk(32'(resp), 32'(rows[j].r));
      end
      rd(rows[j].a, data, resp);
      chk(data, rows[j].e);
      chk(32'(resp), 32'(rows[j].r));
    end
    wr(8'h00, 32'h18, resp);
    v_lvl[0] <= 16'h4000;
    i_lvl[0] <= 16'hC000;
    wait_num(1'b1);
    rd(8'h20, vrms0, resp);
    rd(8'h08, data, resp);
    chk(data, 32'h0);
    i_lvl[0] <= 16'h4000;
    wait_num(1'b0);
    rd(8'h08, data, resp);
    chk(data, 32'h0);
    wr(8'h00, 32'h1C, resp);
    i_lvl[0] <= 16'hC000;
    k = 0;
    while (irq_n !== 1'b0 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    chk(32'(irq_n), 32'h0);
    if (irq_n !== 1'b0) give_verdict;
    rd(8'h08, data, resp);
    chk(data, 32'h20000);
    rd(8'h04, data, resp);
    chk(data, 32'h8000);
    wr(8'h0C, 32'h20000, resp);
    rd(8'h08, data, resp);
    chk(data, 32'h0);
    chk(32'(irq_n), 32'h1);
    wr(8'h10, 32'h0, resp);
    i_lvl[0] <= 16'h4000;
    wait_num(1'b0);
    rd(8'h08, data, resp);
    chk(data, 32'h20000);
    chk(32'(irq_n), 32'h1);
    repeat (2000) @(posedge clock);
    rd(8'h20, data, resp);
    chk(32'(data > vrms0), 32'h1);
    give_verdict;
  end
endmodule
`default_nettype wire
